// ### core/lcdd_pkg.sv
// Constants shared by the LCD drive control block
package lcdd_pkg;

	// Register bus
	localparam int LCDD_DATA_W = 8;
	localparam int LCDD_VSEL_W = 3;
	localparam logic [7:0] LCDD_ADDR_CTRL = 8'hf0;
	localparam logic [7:0] LCDD_ADDR_VSEL = 8'hf1;
	localparam logic [7:0] LCDD_CTRL_RESET = 8'h00;
	localparam logic [2:0] LCDD_VSEL_RESET = 3'h0;
	localparam logic [4:0] LCDD_VSEL_UNUSED = 5'h00;
	localparam logic [7:0] LCDD_RDATA_NONE = 8'h00;

	// Control field positions
	localparam int LCDD_CLKSEL_HI = 7;
	localparam int LCDD_CLKSEL_LO = 6;
	localparam int LCDD_DUTY_HI = 5;
	localparam int LCDD_DUTY_LO = 3;
	localparam int LCDD_BIAS_HI = 2;
	localparam int LCDD_BIAS_LO = 1;
	localparam int LCDD_DISP_BIT = 0;

	// Frame clock select codes and divider terminal counts
	localparam logic [1:0] LCDD_CLK_DIV256 = 2'h0;
	localparam logic [1:0] LCDD_CLK_DIV128 = 2'h1;
	localparam logic [1:0] LCDD_CLK_DIV64 = 2'h2;
	localparam logic [1:0] LCDD_CLK_DIV32 = 2'h3;
	localparam logic [7:0] LCDD_TERM_DIV256 = 8'hff;
	localparam logic [7:0] LCDD_TERM_DIV128 = 8'h7f;
	localparam logic [7:0] LCDD_TERM_DIV64 = 8'h3f;
	localparam logic [7:0] LCDD_TERM_DIV32 = 8'h1f;

	// Duty and bias select codes
	localparam logic [2:0] LCDD_DB_8_4 = 3'h0;
	localparam logic [2:0] LCDD_DB_4_3 = 3'h1;
	localparam logic [2:0] LCDD_DB_3_3 = 3'h2;
	localparam logic [2:0] LCDD_DB_3_2 = 3'h3;
	localparam logic [3:0] LCDD_DUTY_8 = 4'h8;
	localparam logic [3:0] LCDD_DUTY_4 = 4'h4;
	localparam logic [3:0] LCDD_DUTY_3 = 4'h3;
	localparam logic [3:0] LCDD_DUTY_2 = 4'h2;
	localparam logic [3:0] LCDD_DUTY_STEP = 4'h1;
	localparam logic [2:0] LCDD_BIAS_4 = 3'h4;
	localparam logic [2:0] LCDD_BIAS_3 = 3'h3;
	localparam logic [2:0] LCDD_BIAS_2 = 3'h2;

	// Bias type codes
	localparam logic [1:0] LCDD_BIAS_GPIO = 2'h0;
	localparam logic [1:0] LCDD_BIAS_CAP = 2'h1;
	localparam logic [1:0] LCDD_BIAS_INT_RES = 2'h2;
	localparam logic [1:0] LCDD_BIAS_EXT_RES = 2'h3;

	// Highest legal drive-voltage codes
	localparam logic [2:0] LCDD_VMAX_THIRD_RUN = 3'h6;
	localparam logic [2:0] LCDD_VMAX_HALF_RUN = 3'h4;
	localparam logic [2:0] LCDD_VMAX_THIRD_LP = 3'h2;
	localparam logic [2:0] LCDD_VMAX_HALF_LP = 3'h1;

	// Divider counter width
	localparam int LCDD_DIV_W = 8;
	localparam logic [7:0] LCDD_DIV_ZERO = 8'h00;
	localparam logic [7:0] LCDD_DIV_STEP = 8'h01;

endpackage

// ### core/lcdd_sync_edge.sv
// Two-flop synchroniser with rising-edge pulse for the watch-timer clock
`timescale 1ns/1ps
module lcdd_sync_edge (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Asynchronous level
	input wire logic async_in,
	// Synchronised level and edge pulse
	output logic level_out,
	output logic rise_out
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} lcdd_sync_t;

	lcdd_sync_t q;
	lcdd_sync_t next_q;

	always_comb begin
		next_q = q;
		next_q.s1 = async_in;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		// Edge looks only at the second and third stage
		next_q.rise = q.s2 & ~q.s3;
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign level_out = q.s2;
	assign rise_out = q.rise;

endmodule // lcdd_sync_edge

// ### core/lcdd_frame_divider.sv
// Watch-timer divider producing the LCD frame clock tick
`timescale 1ns/1ps
module lcdd_frame_divider #(
	parameter int DIV_W = lcdd_pkg::LCDD_DIV_W
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Control
	input wire logic step_in,
	input wire logic restart_in,
	input wire logic [1:0] clk_sel_in,
	// Frame tick
	output logic tick_out
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} lcdd_div_t;

	lcdd_div_t q;
	lcdd_div_t next_q;
	logic [DIV_W-1:0] term;

	always_comb begin
		unique case (clk_sel_in)
			lcdd_pkg::LCDD_CLK_DIV256: term = DIV_W'(lcdd_pkg::LCDD_TERM_DIV256);
			lcdd_pkg::LCDD_CLK_DIV128: term = DIV_W'(lcdd_pkg::LCDD_TERM_DIV128);
			lcdd_pkg::LCDD_CLK_DIV64: term = DIV_W'(lcdd_pkg::LCDD_TERM_DIV64);
			default: term = DIV_W'(lcdd_pkg::LCDD_TERM_DIV32);
		endcase
	end

	always_comb begin
		next_q = q;
		next_q.tick = 1'b0;
		if (restart_in) begin
			next_q.cnt = DIV_W'(lcdd_pkg::LCDD_DIV_ZERO);
		end else if (step_in) begin
			// Compare with >= so a faster select taken mid-count wraps at once
			if (q.cnt >= term) begin
				next_q.cnt = DIV_W'(lcdd_pkg::LCDD_DIV_ZERO);
				next_q.tick = 1'b1;
			end else begin
				next_q.cnt = q.cnt + DIV_W'(lcdd_pkg::LCDD_DIV_STEP);
			end
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign tick_out = q.tick;

endmodule // lcdd_frame_divider

// ### core/lcdd_drive_control.sv
// LCD drive control: control registers, frame clock, pin takeover, booster gating
// Notes on behaviour
// - Bits 7:6 divide watch clock by 256..32
// - Bits 5:3 choose duty and bias pair
// - Bias type 00 leaves bias pins general
// - Capacitor bias claims four bias, two pump pins
// - Resistor bias stops booster, claims four pins
// - Display bit off forces outputs low, booster off
// - Control write restarts divider and duty sequence
// - Mode bits 2:0 give voltage, capacitor only
// - Booster clock taken from watch clock
`timescale 1ns/1ps
module lcdd_drive_control (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Watch-timer clock pin and power mode
	input wire logic watch_timer_clock_in,
	input wire logic low_power_mode_in,
	// Frame timing
	output logic lcd_clk_tick_out,
	output logic [2:0] com_index_out,
	output logic frame_start_out,
	output logic frame_phase_out,
	output logic reinit_out,
	// Drive scheme
	output logic [3:0] duty_count_out,
	output logic [2:0] bias_divisor_out,
	output logic lcd_outputs_low_out,
	// Port five pin takeover
	output logic [3:0] bias_level_pins_select_out,
	output logic [1:0] pump_cap_pins_select_out,
	// Booster
	output logic booster_run_out,
	output logic booster_connect_out,
	output logic booster_clk_out,
	output logic [2:0] boosted_drive_voltage_code_out,
	output logic boosted_drive_voltage_legal_out
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [2:0] vsel;
		logic [7:0] rdata;
		logic rvalid;
		logic reinit;
		logic lcd_tick;
		logic [2:0] com;
		logic frame_start;
		logic phase;
		logic [3:0] duty;
		logic [2:0] biasd;
		logic low;
		logic [3:0] bias_sel;
		logic [1:0] cap_sel;
		logic boost_run;
		logic boost_conn;
		logic boost_clk;
		logic [2:0] vcode;
		logic vlegal;
	} lcdd_state_t;

	// Pin-select masks and small codes used by the decode below
	localparam logic [3:0] LCDD_BIAS_PINS_NONE = 4'h0;
	localparam logic [3:0] LCDD_BIAS_PINS_ALL = 4'hf;
	localparam logic [1:0] LCDD_CAP_PINS_NONE = 2'h0;
	localparam logic [1:0] LCDD_CAP_PINS_ALL = 2'h3;
	localparam logic [2:0] LCDD_VMAX_QUARTER = 3'h7;
	localparam logic [2:0] LCDD_COM_FIRST = 3'h0;
	localparam logic [2:0] LCDD_COM_STEP = 3'h1;
	localparam logic [2:0] LCDD_VCODE_NONE = 3'h0;

	// Every field listed so the dark, slowest state after reset is explicit
	localparam lcdd_state_t LCDD_STATE_RESET = '{
		ctrl: lcdd_pkg::LCDD_CTRL_RESET,
		vsel: lcdd_pkg::LCDD_VSEL_RESET,
		rdata: lcdd_pkg::LCDD_RDATA_NONE,
		rvalid: 1'b0,
		reinit: 1'b0,
		lcd_tick: 1'b0,
		com: LCDD_COM_FIRST,
		frame_start: 1'b0,
		phase: 1'b0,
		duty: lcdd_pkg::LCDD_DUTY_8,
		biasd: lcdd_pkg::LCDD_BIAS_4,
		low: 1'b1,
		bias_sel: LCDD_BIAS_PINS_NONE,
		cap_sel: LCDD_CAP_PINS_NONE,
		boost_run: 1'b0,
		boost_conn: 1'b0,
		boost_clk: 1'b0,
		vcode: LCDD_VCODE_NONE,
		vlegal: 1'b1
	};

	lcdd_state_t q;
	lcdd_state_t next_q;

	logic fw_level;
	logic fw_tick;
	logic frame_tick;
	logic wr_ctrl;
	logic wr_vsel;
	logic [1:0] clk_sel;
	logic [2:0] duty_sel;
	logic [1:0] bias_type;
	logic disp_on;
	logic cap_bias;
	logic [3:0] duty_dec;
	logic [2:0] bias_dec;
	logic [2:0] vmax;
	logic [3:0] com_last;

	// Watch clock arrives from another domain
	lcdd_sync_edge u_fw_sync (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.async_in(watch_timer_clock_in),
		.level_out(fw_level),
		.rise_out(fw_tick)
	);

	lcdd_frame_divider #(
		.DIV_W(lcdd_pkg::LCDD_DIV_W)
	) u_frame_div (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.step_in(fw_tick),
		.restart_in(wr_ctrl),
		.clk_sel_in(clk_sel),
		.tick_out(frame_tick)
	);

	assign wr_ctrl = reg_wr_in && (reg_addr_in == lcdd_pkg::LCDD_ADDR_CTRL);
	assign wr_vsel = reg_wr_in && (reg_addr_in == lcdd_pkg::LCDD_ADDR_VSEL);

	// Field split of the stored control byte
	assign clk_sel = q.ctrl[lcdd_pkg::LCDD_CLKSEL_HI:lcdd_pkg::LCDD_CLKSEL_LO];
	assign duty_sel = q.ctrl[lcdd_pkg::LCDD_DUTY_HI:lcdd_pkg::LCDD_DUTY_LO];
	assign bias_type = q.ctrl[lcdd_pkg::LCDD_BIAS_HI:lcdd_pkg::LCDD_BIAS_LO];
	assign disp_on = q.ctrl[lcdd_pkg::LCDD_DISP_BIT];
	assign cap_bias = (bias_type == lcdd_pkg::LCDD_BIAS_CAP);
	assign com_last = duty_dec - lcdd_pkg::LCDD_DUTY_STEP;

	always_comb begin
		unique casez (duty_sel)
			lcdd_pkg::LCDD_DB_8_4: begin
				duty_dec = lcdd_pkg::LCDD_DUTY_8;
				bias_dec = lcdd_pkg::LCDD_BIAS_4;
			end
			lcdd_pkg::LCDD_DB_4_3: begin
				duty_dec = lcdd_pkg::LCDD_DUTY_4;
				bias_dec = lcdd_pkg::LCDD_BIAS_3;
			end
			lcdd_pkg::LCDD_DB_3_3: begin
				duty_dec = lcdd_pkg::LCDD_DUTY_3;
				bias_dec = lcdd_pkg::LCDD_BIAS_3;
			end
			lcdd_pkg::LCDD_DB_3_2: begin
				duty_dec = lcdd_pkg::LCDD_DUTY_3;
				bias_dec = lcdd_pkg::LCDD_BIAS_2;
			end
			default: begin
				// Any code with the top bit set
				duty_dec = lcdd_pkg::LCDD_DUTY_2;
				bias_dec = lcdd_pkg::LCDD_BIAS_2;
			end
		endcase
	end

	// Legal voltage ceiling per bias and power mode
	always_comb begin
		if (bias_dec == lcdd_pkg::LCDD_BIAS_4) begin
			vmax = LCDD_VMAX_QUARTER;
		end else if (bias_dec == lcdd_pkg::LCDD_BIAS_3) begin
			vmax = low_power_mode_in ? lcdd_pkg::LCDD_VMAX_THIRD_LP
				: lcdd_pkg::LCDD_VMAX_THIRD_RUN;
		end else begin
			vmax = low_power_mode_in ? lcdd_pkg::LCDD_VMAX_HALF_LP
				: lcdd_pkg::LCDD_VMAX_HALF_RUN;
		end
	end

	always_comb begin
		next_q = q;
		next_q.rvalid = 1'b0;
		next_q.reinit = 1'b0;
		next_q.lcd_tick = frame_tick;
		next_q.frame_start = 1'b0;

		// Register writes
		if (wr_ctrl) begin
			next_q.ctrl = reg_wdata_in;
			next_q.reinit = 1'b1;
		end
		if (wr_vsel) begin
			next_q.vsel = reg_wdata_in[lcdd_pkg::LCDD_VSEL_W-1:0];
		end

		// Register reads return the value before a same-cycle write
		if (reg_rd_in) begin
			next_q.rvalid = 1'b1;
			if (reg_addr_in == lcdd_pkg::LCDD_ADDR_CTRL) begin
				next_q.rdata = q.ctrl;
			end else if (reg_addr_in == lcdd_pkg::LCDD_ADDR_VSEL) begin
				next_q.rdata = {lcdd_pkg::LCDD_VSEL_UNUSED, q.vsel};
			end else begin
				next_q.rdata = lcdd_pkg::LCDD_RDATA_NONE;
			end
		end

		// Common sequencing; held at the first common while dark
		if (wr_ctrl || !disp_on) begin
			next_q.com = LCDD_COM_FIRST;
			next_q.phase = 1'b0;
		end else if (frame_tick) begin
			if ({1'b0, q.com} >= com_last) begin
				next_q.com = LCDD_COM_FIRST;
				next_q.frame_start = 1'b1;
				// Alternate polarity each frame so the glass sees no DC
				next_q.phase = ~q.phase;
			end else begin
				next_q.com = q.com + LCDD_COM_STEP;
			end
		end

		// Drive scheme and pin takeover
		next_q.duty = duty_dec;
		next_q.biasd = bias_dec;
		next_q.low = !disp_on;
		// Resistor taps need the four bias pins; the pump pins stay general
		unique case (bias_type)
			lcdd_pkg::LCDD_BIAS_GPIO: begin
				next_q.bias_sel = LCDD_BIAS_PINS_NONE;
				next_q.cap_sel = LCDD_CAP_PINS_NONE;
			end
			lcdd_pkg::LCDD_BIAS_CAP: begin
				next_q.bias_sel = LCDD_BIAS_PINS_ALL;
				next_q.cap_sel = LCDD_CAP_PINS_ALL;
			end
			lcdd_pkg::LCDD_BIAS_INT_RES: begin
				next_q.bias_sel = LCDD_BIAS_PINS_ALL;
				next_q.cap_sel = LCDD_CAP_PINS_NONE;
			end
			lcdd_pkg::LCDD_BIAS_EXT_RES: begin
				next_q.bias_sel = LCDD_BIAS_PINS_ALL;
				next_q.cap_sel = LCDD_CAP_PINS_NONE;
			end
		endcase

		// Booster runs only when lit and on capacitor bias
		next_q.boost_run = disp_on && cap_bias;
		next_q.boost_conn = disp_on && cap_bias;
		next_q.boost_clk = fw_level && disp_on && cap_bias;

		// Voltage code is meaningful only under capacitor bias
		// Codes are flagged, not clipped: the stored value still reaches the booster
		if (cap_bias) begin
			next_q.vcode = q.vsel;
			next_q.vlegal = (q.vsel <= vmax);
		end else begin
			next_q.vcode = LCDD_VCODE_NONE;
			next_q.vlegal = 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= LCDD_STATE_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata_out = q.rdata;
	assign reg_rvalid_out = q.rvalid;
	assign lcd_clk_tick_out = q.lcd_tick;
	assign com_index_out = q.com;
	assign frame_start_out = q.frame_start;
	assign frame_phase_out = q.phase;
	assign reinit_out = q.reinit;
	assign duty_count_out = q.duty;
	assign bias_divisor_out = q.biasd;
	assign lcd_outputs_low_out = q.low;
	assign bias_level_pins_select_out = q.bias_sel;
	assign pump_cap_pins_select_out = q.cap_sel;
	assign booster_run_out = q.boost_run;
	assign booster_connect_out = q.boost_conn;
	assign booster_clk_out = q.boost_clk;
	assign boosted_drive_voltage_code_out = q.vcode;
	assign boosted_drive_voltage_legal_out = q.vlegal;

endmodule // lcdd_drive_control

// ### dv/lcdd_drive_control_props.sv
// Assertion checker for the LCD drive control ports
`timescale 1ns/1ps
module lcdd_drive_control_props (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic reg_rvalid_out,
	input wire logic reinit_out,
	input wire logic [2:0] com_index_out,
	input wire logic [3:0] duty_count_out,
	input wire logic [2:0] bias_divisor_out,
	input wire logic lcd_outputs_low_out,
	input wire logic [3:0] bias_level_pins_select_out,
	input wire logic [1:0] pump_cap_pins_select_out,
	input wire logic booster_run_out,
	input wire logic booster_connect_out,
	input wire logic booster_clk_out,
	input wire logic [2:0] boosted_drive_voltage_code_out,
	input wire logic boosted_drive_voltage_legal_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	reinit_on_write_a: assert property (reg_wr_in && reg_addr_in == 8'hf0 |=> reinit_out)
		else $error("control write gave no restart");
	reinit_cause_a: assert property (reinit_out |-> $past(reg_wr_in) && $past(reg_addr_in) == 8'hf0)
		else $error("restart without control write");
	read_answer_a: assert property (reg_rvalid_out == $past(reg_rd_in))
		else $error("read valid misplaced");
	pump_pins_a: assert property (pump_cap_pins_select_out != 2'h0 |-> pump_cap_pins_select_out == 2'h3 && bias_level_pins_select_out == 4'hf)
		else $error("pump pins taken without bias pins");
	booster_gate_a: assert property (booster_run_out |-> pump_cap_pins_select_out == 2'h3 && !lcd_outputs_low_out)
		else $error("booster runs outside capacitor display");
	booster_pair_a: assert property (booster_connect_out == booster_run_out)
		else $error("booster connect differs from run");
	booster_clock_a: assert property (booster_clk_out |-> booster_run_out || $past(booster_run_out))
		else $error("booster clock while stopped");
	com_hold_a: assert property (lcd_outputs_low_out && !reinit_out |=> $stable(com_index_out))
		else $error("commons advance with display off");
	com_range_a: assert property ({1'b0, com_index_out} < duty_count_out)
		else $error("common index beyond duty");
	duty_bias_a: assert property ((duty_count_out == 4'h8) == (bias_divisor_out == 3'h4))
		else $error("duty and bias mismatched");
	vsel_gate_a: assert property (pump_cap_pins_select_out == 2'h0 |-> boosted_drive_voltage_code_out == 3'h0 && boosted_drive_voltage_legal_out)
		else $error("voltage code outside capacitor bias");
endmodule // lcdd_drive_control_props

bind lcdd_drive_control lcdd_drive_control_props lcdd_drive_control_props_inst (
	.clock_in, .resetn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rvalid_out,
	.reinit_out, .com_index_out, .duty_count_out, .bias_divisor_out, .lcd_outputs_low_out,
	.bias_level_pins_select_out, .pump_cap_pins_select_out, .booster_run_out,
	.booster_connect_out, .booster_clk_out, .boosted_drive_voltage_code_out,
	.boosted_drive_voltage_legal_out
);

// ### dv/lcdd_panel_model.sv
// Panel-side model: watch oscillator source and frame monitor
`timescale 1ns/1ps
module lcdd_panel_model (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [2:0] com_index_in,
	input wire logic [3:0] duty_count_in,
	input wire logic frame_start_in,
	output logic watch_clk_out,
	output int frames_out,
	output int bad_out
);
	// Sped up to 8 system clocks per half cycle to keep runs short
	initial begin
		watch_clk_out = 1'b0;
		#3;
		forever #80 watch_clk_out = ~watch_clk_out;
	end
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			frames_out <= 0;
			bad_out <= 0;
		end else begin
			if (frame_start_in) frames_out <= frames_out + 1;
			if ({1'b0, com_index_in} >= duty_count_in) bad_out <= bad_out + 1;
		end
	end
endmodule // lcdd_panel_model

// ### dv/tb_lcdd_drive_control.sv
// Self-checking bench for the LCD drive control block
`timescale 1ns/1ps
module tb_lcdd_drive_control;
	logic clock_in, resetn_in, reg_wr_in, reg_rd_in, low_power_mode_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
	logic reg_rvalid_out, watch_timer_clock_in, lcd_clk_tick_out;
	logic frame_start_out, frame_phase_out, reinit_out, lcd_outputs_low_out;
	logic booster_run_out, booster_connect_out, booster_clk_out;
	logic boosted_drive_voltage_legal_out;
	logic [2:0] com_index_out, bias_divisor_out, boosted_drive_voltage_code_out;
	logic [3:0] duty_count_out, bias_level_pins_select_out;
	logic [1:0] pump_cap_pins_select_out;
	int fails, compares, cycles, n, frames, bad, i, k;
	// Voltage cases: duty code, low power, code, expected legal
	localparam logic [7:0] VTAB [11] = '{8'h0f, 8'h1f, 8'h2e, 8'h2d, 8'h36, 8'h35,
		8'h6a, 8'h69, 8'h74, 8'h73, 8'h8a};
	// Shortened settling wait; keeps the run well inside budget
	localparam int SETTLE = 200;

	lcdd_drive_control lcdd_drive_control_inst (
		.clock_in, .resetn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
		.reg_rdata_out, .reg_rvalid_out, .watch_timer_clock_in, .low_power_mode_in,
		.lcd_clk_tick_out, .com_index_out, .frame_start_out, .frame_phase_out, .reinit_out,
		.duty_count_out, .bias_divisor_out, .lcd_outputs_low_out, .bias_level_pins_select_out,
		.pump_cap_pins_select_out, .booster_run_out, .booster_connect_out, .booster_clk_out,
		.boosted_drive_voltage_code_out, .boosted_drive_voltage_legal_out
	);
	lcdd_panel_model lcdd_panel_model_inst (
		.clock_in, .resetn_in, .com_index_in(com_index_out), .duty_count_in(duty_count_out),
		.frame_start_in(frame_start_out), .watch_clk_out(watch_timer_clock_in),
		.frames_out(frames), .bad_out(bad)
	);

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			test_done();
		end
	end

	task automatic test_done();
		$display("Compares %0d, fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clock_in);
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		@(negedge clock_in);
		reg_wr_in = 1'b0;
		chk(reinit_out, a == 8'hf0);
		@(negedge clock_in);
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clock_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge clock_in);
		reg_rd_in = 1'b0;
		chk(reg_rvalid_out, 1'b1);
		d = reg_rdata_out;
	endtask
	task automatic wait_tick();
		n = 0;
		do begin
			@(negedge clock_in);
			n++;
		end while (lcd_clk_tick_out !== 1'b1 && n < 5000);
	endtask
	function automatic logic [3:0] exp_duty(input logic [2:0] c);
		return c[2] ? 4'h2 : (c == 3'h0) ? 4'h8 : (c == 3'h1) ? 4'h4 : 4'h3;
	endfunction
	function automatic logic [2:0] exp_bias(input logic [2:0] c);
		return (c[2] || c == 3'h3) ? 3'h2 : (c == 3'h0) ? 3'h4 : 3'h3;
	endfunction

	initial begin
		resetn_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		low_power_mode_in = 1'b0;
		repeat (6) @(posedge clock_in);
		@(negedge clock_in);
		resetn_in = 1'b1;
		chk({duty_count_out, bias_divisor_out}, 7'h44);
		chk({lcd_outputs_low_out, booster_run_out, bias_level_pins_select_out}, 6'h20);
		rd(8'hf0);
		chk(d, 8'h00);
		wr(8'hf1, 8'hff);
		rd(8'hf1);
		chk(d, 8'h07);
		wr(8'he0, 8'h3c);
		rd(8'hf0);
		chk(d, 8'h00);
		rd(8'he0);
		chk(d, 8'h00);
		for (i = 0; i < 8; i++) begin
			wr(8'hf0, {2'h0, i[2:0], 3'h0});
			chk(duty_count_out, exp_duty(i[2:0]));
			chk(bias_divisor_out, exp_bias(i[2:0]));
			rd(8'hf0);
			chk(d, {2'h0, i[2:0], 3'h0});
		end
		// Index is {bias type, display}
		for (i = 0; i < 8; i++) begin
			if (i == 3) repeat (SETTLE) @(negedge clock_in);
			if (i != 1) begin
				wr(8'hf0, {5'h00, i[2:0]});
				chk(bias_level_pins_select_out, (i[2:1] != 0) ? 4'hf : 4'h0);
				chk(pump_cap_pins_select_out, (i[2:1] == 1) ? 2'h3 : 2'h0);
				chk({booster_run_out, booster_connect_out}, (i == 3) ? 2'h3 : 2'h0);
				chk(lcd_outputs_low_out, !i[0]);
			end
		end
		// Capacitor bias first, lit only after it has settled
		wr(8'hf0, 8'h02);
		repeat (SETTLE) @(negedge clock_in);
		for (i = 0; i < 2; i++) begin
			wr(8'hf0, {7'h01, !i[0]});
			k = 0;
			repeat (160) begin
				@(negedge clock_in);
				k += int'(booster_clk_out === 1'b1);
			end
			chk(k > 70 && k < 90, i == 0);
		end
		for (i = 0; i < 11; i++) begin
			low_power_mode_in = VTAB[i][4];
			wr(8'hf0, {2'h0, VTAB[i][7:5], 3'h3});
			wr(8'hf1, {5'h00, VTAB[i][3:1]});
			chk(boosted_drive_voltage_code_out, VTAB[i][3:1]);
			chk(boosted_drive_voltage_legal_out, VTAB[i][0]);
		end
		low_power_mode_in = 1'b0;
		wr(8'hf0, 8'h07);
		chk(boosted_drive_voltage_code_out, 3'h0);
		for (i = 0; i < 4; i++) begin
			wr(8'hf0, {i[1:0], 6'h07});
			wait_tick();
			chk(n > (256 >> i) * 16 - 32, 1'b1);
			wait_tick();
			chk(n, (256 >> i) * 16);
		end
		// Half duty: the second tick wraps the commons and flips the phase
		wr(8'hf0, 8'he7);
		k = frames;
		repeat (2) wait_tick();
		chk({frame_start_out, frame_phase_out, com_index_out}, 5'h18);
		repeat (2) wait_tick();
		@(negedge clock_in);
		chk(frames - k, 2);
		chk(bad, 0);
		wr(8'hf0, 8'he6);
		k = frames;
		repeat (4) wait_tick();
		chk(frames == k && com_index_out == 3'h0, 1'b1);
		chk(frame_phase_out, 1'b0);
		resetn_in = 1'b0;
		@(negedge clock_in);
		resetn_in = 1'b1;
		chk({duty_count_out, bias_divisor_out}, 7'h44);
		chk({lcd_outputs_low_out, booster_run_out, bias_level_pins_select_out}, 6'h20);
		rd(8'hf0);
		chk(d, 8'h00);
		test_done();
	end
endmodule // tb_lcdd_drive_control
